// ---- src/vie_defs.vh ----
// Constants of the vectored interrupt encoder: register offsets, field
// positions, reset values and source layout.
// Assumes inclusion by bare name from the design files under src/.
`ifndef VIE_DEFS_VH
`define VIE_DEFS_VH

// Register byte offsets on the APB bus
`define VIE_OFF_VECTOR   8'h00
`define VIE_OFF_CONFIG   8'h04
`define VIE_OFF_ENABLE   8'h08
`define VIE_OFF_PENDING  8'h0C

// Field positions
`define VIE_CFG_PORTSEL_BIT  0
`define VIE_EN_EXT_ONE_BIT   2
`define VIE_VEC_CODE_LSB     1
`define VIE_VEC_GROUP_LSB    4

// Reset values
`define VIE_VECTOR_RESET  8'h00
`define VIE_CONFIG_RESET  1'b0
`define VIE_ENABLE_RESET  1'b0

// Source layout: groups 1 to 4 hold sources, eight codes each
`define VIE_CODES_PER_GROUP  8
`define VIE_NUM_GROUPS       4
`define VIE_FIRST_GROUP      3'h1
`define VIE_NUM_SLOTS        32
// Slots that carry a real source; the rest are reserved codes
`define VIE_SLOT_VALID       32'h0F7F0E0E

`endif

// ---- src/vie_sync2.v ----
// Two-flop level synchroniser for pins arriving from outside the clock.
// Assumes clk and an active-low asynchronous reset; resets to a chosen level.
`timescale 1ns/1ps
`default_nettype none

module vie_sync2 #(
  parameter       WIDTH     = 1,
  parameter [0:0] RESET_VAL = 1'b1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageOneQ;

  // First stage is read only by the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stageOneQ <= {WIDTH{RESET_VAL}};
      syncOut   <= {WIDTH{RESET_VAL}};
    end else begin
      stageOneQ <= asyncIn;
      syncOut   <= stageOneQ;
    end
  end

endmodule

`default_nettype wire

// ---- src/vie_vectored_interrupt_encoder.v ----
// Vectored interrupt encoder: peripheral events into one internal interrupt
// line with a prioritised vector register, plus the port-two interrupt path.
// Assumes one 10 MHz clock, APB register access, peripheral events from logic
// on the same clock, and port pins that are asynchronous.
//
// How it works
// - All peripheral requests ORed onto internal line
// - Package interrupt pins never feed the internal line
// - Vector space has room for 128 vectors
// - Vector shows source that caused the trap; here it shows the best pending source, and a higher arrival replaces it
// - Any write retires vector, loads next pending
// - Vector bit zero always reads zero
// - Vector reads zero when nothing pending
// - Code in bits 3-1, group 7-4, reset zero
// - Within a group, oldest request served first
// - Higher group number wins over lower
// - Groups 1, 2: endpoints 1-3 at codes 1-3
// - Group 3 bus events, group 4 I2C/ep0
// - Fixed encoder for ties; 46h highest, 12h lowest
// - Port-two low inputs ORed into port line
// - Port-two OR also drives wake-up logic
// - Select bit picks pin or port-two OR
// - Enable bit 2 gates port interrupt, resets 0
//
// Register map, one 32-bit word each, unused bits read zero:
//   00h vector, read only; any write retires the shown source
//   04h bit 0 picks the port source: 0 pin three, 1 port two
//   08h bit 2 enables the port interrupt toward the core
//   0Ch pending bitmap, read only, bit = (group - 1) * 8 + code
// Limitation: sources are sampled as levels, so a held event re-arms
// its slot on every cycle it stays high, even right after a retire.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vie_defs.vh"

module vie_vectored_interrupt_encoder #(
  parameter ADDR_WIDTH = 8
) (
  input  wire                  clk,
  input  wire                  rst_n,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]           pwdata,
  output reg                   pready,
  output reg  [31:0]           prdata,
  output reg                   pslverr,
  // Peripheral event pulses, same clock
  input  wire [3:0]            outEndpointEvent,
  input  wire [3:0]            inEndpointEvent,
  input  wire                  setupOverwriteEvent,
  input  wire                  setupPacketEvent,
  input  wire                  powerOnEvent,
  input  wire                  powerOffEvent,
  input  wire                  resumeRequestEvent,
  input  wire                  suspendRequestEvent,
  input  wire                  busResetEvent,
  input  wire                  txEmptyFlag,
  input  wire                  rxFullFlag,
  // Asynchronous active-low pins
  input  wire [7:0]            portTwoInputs_n,
  input  wire                  portThreePinThree_n,
  // Toward the core and wake-up logic
  output reg                   internalIrqLine_n,
  output reg                   portIrqLine_n,
  output reg                   portTwoWake_n
);

  // Slot count and codes per group, fixed by the vector layout
  localparam NS = `VIE_NUM_SLOTS;
  localparam NC = `VIE_CODES_PER_GROUP;

  // Build vector value from slot index
  function [7:0] slotVector;
    input [4:0] slot;
    reg   [3:0] grp;
    begin
      grp = {2'b00, slot[4:3]} + {1'b0, `VIE_FIRST_GROUP};
      slotVector = {grp, slot[2:0], 1'b0};
    end
  endfunction

  // Slot index of a code within a group; slots 0-7 belong to group 1
  function [4:0] slotOf;
    input [1:0] grpIdx;
    input [2:0] code;
    begin
      slotOf = {grpIdx, code};
    end
  endfunction

  reg  [NS-1:0] pendQ;
  reg  [NS-1:0] olderQ [0:NS-1];
  reg  [7:0]    vectorQ;
  reg  [4:0]    shownSlotQ;
  reg           shownValidQ;
  reg           portSelQ;
  reg           extOneEnQ;
  wire [7:0]    portTwoSync_n;
  wire          pinThreeSync_n;

  // Map peripheral events onto group and code slots
  // Code 0 of groups 1 and 2 stays reserved; endpoint 0 sits in group 4
  wire [NS-1:0] srcReq;
  assign srcReq[7:0]   = {4'h0, outEndpointEvent[3:1], 1'b0};
  assign srcReq[15:8]  = {4'h0, inEndpointEvent[3:1], 1'b0};
  assign srcReq[23:16] = {1'b0, busResetEvent, suspendRequestEvent, resumeRequestEvent,
                          powerOffEvent, powerOnEvent, setupPacketEvent,
                          setupOverwriteEvent};
  assign srcReq[31:24] = {4'h0, outEndpointEvent[0], inEndpointEvent[0],
                          rxFullFlag, txEmptyFlag};

  // APB decode
  wire apbAccess = psel & penable & pready;
  wire apbWrite  = apbAccess & pwrite;
  wire hitVector = (paddr == `VIE_OFF_VECTOR);
  wire hitConfig = (paddr == `VIE_OFF_CONFIG);
  wire hitEnable = (paddr == `VIE_OFF_ENABLE);
  wire hitPend   = (paddr == `VIE_OFF_PENDING);
  wire mapped    = hitVector | hitConfig | hitEnable | hitPend;

  // Acknowledge retires the slot shown at the moment of the write
  // If a higher source replaced the vector since the read, that one is retired
  wire          ackWrite = apbWrite & hitVector & shownValidQ;
  wire [NS-1:0] ackMask  = ackWrite ? ({{(NS-1){1'b0}}, 1'b1} << shownSlotQ) : {NS{1'b0}};
  wire [NS-1:0] pendKept = pendQ & ~ackMask;
  // A set in the same cycle as its acknowledge wins and re-arms the slot
  // Reserved codes are masked here, so they can never reach the vector
  wire [NS-1:0] newSet   = srcReq & `VIE_SLOT_VALID & ~pendKept;
  wire [NS-1:0] pendD    = pendKept | newSet;

  // Pending bits and arrival-order matrix; row i marks slots older than i
  integer i;
  integer j;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendQ <= {NS{1'b0}};
      for (i = 0; i < NS; i = i + 1) begin
        olderQ[i] <= {NS{1'b0}};
      end
    end else begin
      pendQ <= pendD;
      for (i = 0; i < NS; i = i + 1) begin
        for (j = 0; j < NS; j = j + 1) begin
          if (newSet[i]) begin
            // Already waiting, or arriving together at a higher code, counts as older;
            // ties follow the fixed encoder, where the higher code ranks first
            olderQ[i][j] <= pendKept[j] | (newSet[j] & (j > i));
          end else if (newSet[j]) begin
            olderQ[i][j] <= 1'b0;
          end
        end
      end
    end
  end

  // Fixed priority: highest group, then oldest inside it
  reg [4:0] bestSlot;
  reg       bestValid;
  reg       olderPending;
  reg [4:0] slotC;
  reg [4:0] slotK;
  integer   g;
  integer   c;
  integer   k;
  always @* begin
    bestSlot     = 5'h00;
    bestValid    = 1'b0;
    olderPending = 1'b0;
    slotC        = 5'h00;
    slotK        = 5'h00;
    for (g = 0; g < `VIE_NUM_GROUPS; g = g + 1) begin
      for (c = 0; c < NC; c = c + 1) begin
        slotC        = slotOf(g[1:0], c[2:0]);
        olderPending = 1'b0;
        for (k = 0; k < NC; k = k + 1) begin
          slotK = slotOf(g[1:0], k[2:0]);
          // A waiting slot yields only to slots waiting from before it; a slot
          // set again this cycle is younger, whatever its stale row still says
          if (pendKept[slotK] && olderQ[slotC][slotK] && !newSet[slotC]) begin
            olderPending = 1'b1;
          end
          // A fresh arrival is younger than every slot already waiting;
          // among arrivals of one cycle the higher code is served first
          if (newSet[slotC] && (pendKept[slotK] || (newSet[slotK] && k > c))) begin
            olderPending = 1'b1;
          end
        end
        // Later groups overwrite earlier ones, so the highest group wins
        if (pendD[slotC] && !olderPending) begin
          bestSlot  = slotC;
          bestValid = 1'b1;
        end
      end
    end
  end

  // Vector register follows the best pending slot every cycle
  // Nothing is latched: a higher arrival replaces the shown vector at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorQ     <= `VIE_VECTOR_RESET;
      shownSlotQ  <= 5'h00;
      shownValidQ <= 1'b0;
    end else begin
      vectorQ     <= bestValid ? slotVector(bestSlot) : `VIE_VECTOR_RESET;
      shownSlotQ  <= bestSlot;
      shownValidQ <= bestValid;
    end
  end

  // Internal line: core sees only the OR of peripheral requests, not pins
  // Built from the next pending state so the line and vector move together
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      internalIrqLine_n <= 1'b1;
    end else begin
      internalIrqLine_n <= ~(|pendD);
    end
  end

  // Port pins are asynchronous; idle level is high
  // Synchroniser resets to that idle level, so no false request after reset
  vie_sync2 #(
    .WIDTH     (9),
    .RESET_VAL (1'b1)
  ) uPinSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({portThreePinThree_n, portTwoInputs_n}),
    .syncOut ({pinThreeSync_n, portTwoSync_n})
  );

  // Any low port-two input requests; selection then enable gating
  wire portTwoReq = ~(&portTwoSync_n);
  wire portSrcReq = portSelQ ? portTwoReq : ~pinThreeSync_n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portIrqLine_n <= 1'b1;
      portTwoWake_n <= 1'b1;
    end else begin
      portIrqLine_n <= ~(portSrcReq & extOneEnQ);
      portTwoWake_n <= ~portTwoReq;
    end
  end

  // Software registers; writes land at the access edge only
  // An unmapped write matches no hit and leaves every register alone
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portSelQ  <= `VIE_CONFIG_RESET;
      extOneEnQ <= `VIE_ENABLE_RESET;
    end else if (apbWrite) begin
      if (hitConfig) begin
        portSelQ <= pwdata[`VIE_CFG_PORTSEL_BIT];
      end
      if (hitEnable) begin
        extOneEnQ <= pwdata[`VIE_EN_EXT_ONE_BIT];
      end
    end
  end

  // Read mux, sampled in the setup cycle so outputs come from flops
  reg [31:0] readData;
  always @* begin
    readData = 32'h0000_0000;
    if (hitVector) begin
      readData = {24'h000000, vectorQ};
    end else if (hitConfig) begin
      readData[`VIE_CFG_PORTSEL_BIT] = portSelQ;
    end else if (hitEnable) begin
      readData[`VIE_EN_EXT_ONE_BIT] = extOneEnQ;
    end else if (hitPend) begin
      readData = pendQ;
    end
  end

  // APB handshake: ready in the first access cycle, no wait states
  // Trade-off: a read returns state as it stood in the setup cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : readData;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- verification/vie_checker.sv ----
// Concurrent checks on the encoder's ports.
// Assumes binding onto the top module, one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none

module vie_checker #(
  parameter ADDR_WIDTH = 8
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic [3:0]            outEndpointEvent,
  input wire logic                  busResetEvent,
  input wire logic                  txEmptyFlag,
  input wire logic [7:0]            portTwoInputs_n,
  input wire logic                  internalIrqLine_n,
  input wire logic                  portTwoWake_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_irq_on_event: assert property ((|outEndpointEvent) || busResetEvent || txEmptyFlag |=> !internalIrqLine_n)
    else $error("event did not raise internal line");
  chk_vec_bit_zero: assert property (pready && !pwrite && paddr == 0 |-> prdata[0] == 1'b0 && prdata[31:8] == 0)
    else $error("vector bit zero or upper bits set");
  chk_wake_low: assert property ((portTwoInputs_n != 8'hFF) [*3] |=> !portTwoWake_n)
    else $error("wake line not low");
  chk_wake_high: assert property ((portTwoInputs_n == 8'hFF) [*3] |=> portTwoWake_n)
    else $error("wake line not released");
  chk_write_rdata: assert property (pready && pwrite |-> prdata == 0)
    else $error("read data on write");
  chk_unmapped_err: assert property (pready && paddr > 8'h0C |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ---- verification/vie_core_model.sv ----
// Model of the core's two interrupt inputs, level sampled each edge.
// Assumes the encoder's registered interrupt lines on the same clock.
`timescale 1ns/1ps
`default_nettype none

module vie_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic internalIrqLine_n,
  input  wire logic portIrqLine_n,
  output var  logic intTaken,
  output var  logic portTaken
);
  // Level sensing only; an edge-triggered input would lose requests still pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intTaken  <= 1'b0;
      portTaken <= 1'b0;
    end else begin
      intTaken  <= !internalIrqLine_n;
      portTaken <= !portIrqLine_n;
    end
  end
endmodule
`default_nettype wire

// ---- verification/vie_vectored_interrupt_encoder_test.sv ----
// Self-checking bench: APB tasks, event pulses, port pin stimulus.
// Assumes the encoder and core model on one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module vie_vectored_interrupt_encoder_test;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, portTwo_n = 8'hFF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, intLine_n, portLine_n, wake_n, intTaken, portTaken, pin3_n = 1'b1;
  logic rdErr;
  logic [16:0] ev = 17'h0;
  int fails = 0, checks_done = 0, cyc = 0;
  // Event bit order: out ep1-3, in ep1-3, seven bus events, tx, rx, in ep0, out ep0
  logic [7:0] expVec [17] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h34,
                              8'h36, 8'h38, 8'h3A, 8'h3C, 8'h40, 8'h42, 8'h44, 8'h46};

  always #50 clk = ~clk;

  vie_vectored_interrupt_encoder DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .outEndpointEvent({ev[2:0], ev[16]}), .inEndpointEvent({ev[5:3], ev[15]}),
    .setupOverwriteEvent(ev[6]), .setupPacketEvent(ev[7]), .powerOnEvent(ev[8]), .powerOffEvent(ev[9]),
    .resumeRequestEvent(ev[10]), .suspendRequestEvent(ev[11]), .busResetEvent(ev[12]),
    .txEmptyFlag(ev[13]), .rxFullFlag(ev[14]), .portTwoInputs_n(portTwo_n), .portThreePinThree_n(pin3_n),
    .internalIrqLine_n(intLine_n), .portIrqLine_n(portLine_n), .portTwoWake_n(wake_n));
  vie_core_model uCore (.clk(clk), .rst_n(rst_n), .internalIrqLine_n(intLine_n),
    .portIrqLine_n(portLine_n), .intTaken(intTaken), .portTaken(portTaken));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // Setup after an edge, hold until pready is sampled high at a rising edge,
  // take the answer at that edge and only then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [16:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 17'h0;
  endtask

  task automatic vec(input logic [7:0] e);
    apb(1'b0, 8'h00, 32'h0);
    chk("vector", {24'h0, e}, rd);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    chk("line idle", 1'b1, intLine_n);
    $display("test reset done");
    for (int i = 0; i < 17; i++) begin
      pulse(17'h1 << i);
      vec(expVec[i]);
      chk("core trapped", 1'b1, intTaken);
      apb(1'b1, 8'h00, 32'hA5);
      vec(8'h00);
      chk("line released", 1'b1, intLine_n);
    end
    $display("test codes done");
    // Arrivals of one cycle: higher group first, then the higher code inside a group
    pulse(17'h1FFFF);
    for (int g = 4; g >= 1; g--) for (int i = 16; i >= 0; i--) if (expVec[i][7:4] == g) begin
      vec(expVec[i]);
      apb(1'b1, 8'h00, 32'h0);
    end
    vec(8'h00);
    pulse(17'h10000);
    pulse(17'h02000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pending map", 32'h0900_0000, rd);
    vec(8'h46);
    apb(1'b1, 8'h00, 32'h0);
    vec(8'h40);
    apb(1'b1, 8'h00, 32'h0);
    pulse(17'h00001);
    pulse(17'h00002);
    vec(8'h12);
    apb(1'b1, 8'h00, 32'h0);
    // A retired slot that returns is younger than one still waiting, even in its first cycle
    fork
      pulse(17'h00001);
      begin
        @(posedge clk);
        vec(8'h14);
      end
    join
    apb(1'b1, 8'h00, 32'h0);
    vec(8'h12);
    pulse(17'h01000);
    vec(8'h3C);
    apb(1'b1, 8'h00, 32'h0);
    vec(8'h12);
    apb(1'b1, 8'h00, 32'h0);
    $display("test priority done");
    apb(1'b1, 8'h08, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    chk("enable readback", 32'h4, rd);
    pin3_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("pin three selected", 1'b0, portLine_n);
    chk("pins not internal", 1'b1, intLine_n);
    chk("wake idle", 1'b1, wake_n);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("select readback", 32'h1, rd);
    repeat (3) @(posedge clk);
    chk("port two idle", 1'b1, portLine_n);
    portTwo_n <= 8'hDF;
    repeat (5) @(posedge clk);
    chk("port two or", 1'b0, portLine_n);
    chk("port trap", 1'b1, portTaken);
    chk("wake", 1'b0, wake_n);
    apb(1'b1, 8'h08, 32'h0);
    repeat (3) @(posedge clk);
    chk("enable gates", 1'b1, portLine_n);
    chk("wake ungated", 1'b0, wake_n);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 1'b1, rdErr);
    chk("unmapped data", 32'h0, rd);
    $display("test port done");
    conclude();
  end
endmodule

bind vie_vectored_interrupt_encoder vie_checker #(.ADDR_WIDTH(ADDR_WIDTH)) uChk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .outEndpointEvent(outEndpointEvent), .busResetEvent(busResetEvent),
  .txEmptyFlag(txEmptyFlag), .portTwoInputs_n(portTwoInputs_n), .internalIrqLine_n(internalIrqLine_n),
  .portTwoWake_n(portTwoWake_n));
`default_nettype wire
